// [hw/tgp_gpio.sv]
// What this block does
// - Port B: eight pins, dir one input.
// - Port C: eight pins, same direction encoding.
// - Port A six bits, upper two read zero.
// - Option bit 7 low enables B pull-ups.
// - Pull-up off on any output pin.
// - Pull-ups disabled after power-on reset.
// - Only input pins B7..B4 compared.
// - Compare pins against reference latched on read.
// - ORed mismatch sets change flag, control bit0.
// - Change flag can wake from sleep.
// - Port B read or write refreshes reference.
// - Mismatch keeps setting flag; clear after access.
// - B0 external interrupt; all B pull-ups.
// - B6 programming clock, B7 programming data.
// - A4 timer clock input, open-drain output.
// - A5 slave select and analog input.
// - A3 I/O, analog or reference; A0-A2 I/O or analog.
// - Enabled peripheral overrides port C direction.
// - Port A read pins, write loads latch.
// - After reset A analog pins read zero.
// - Analog config bits pick digital or analog.
//
// Added by the designer: register access over AXI4-Lite.
`default_nettype none
module tgp_gpio (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [5:0] pa_pin_i,
  output logic [5:0] pa_out_o,
  output logic [5:0] pa_oe_n_o,
  input wire logic [7:0] pb_pin_i,
  output tgp_pkg::tgp_drive_s pb_drive_o,
  output logic [7:0] pb_pullup_o,
  input wire logic [7:0] pc_pin_i,
  output tgp_pkg::tgp_drive_s pc_drive_o,
  input wire logic [7:0] pc_periph_en_i,
  input wire logic [7:0] pc_periph_dir_i,
  input wire logic [7:0] pc_periph_out_i,
  input wire logic prog_mode_i,
  output logic prog_clk_o,
  output logic prog_data_o,
  output logic ext_int_o,
  output logic timer_ext_clock_in_o,
  output logic slave_select_o,
  output logic [5:0] analog_sel_o,
  output logic vref_sel_o,
  output logic port_change_flag_o
);

  // ****************************************************************
  // Registers.
  // ****************************************************************
  logic [5:0] port_a_data;
  logic [7:0] port_b_data;
  logic [7:0] port_c_data;
  logic [5:0] port_a_direction;
  logic [7:0] port_b_direction;
  logic [7:0] port_c_direction;
  logic [7:0] option_control;
  logic [2:0] analog_pin_config;
  logic [3:0] change_ref;

  // ****************************************************************
  // Bus slave state.
  // ****************************************************************
  tgp_pkg::tgp_wstate_e wstate;
  logic aw_full;
  logic w_full;
  logic [9:0] aw_idx;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic commit;
  logic wr_lane0;
  logic ar_take;
  logic [9:0] ar_idx;
  logic [31:0] next_rdata;
  logic next_rerr;
  logic [5:0] analog_mask;
  logic vref_on;
  logic mismatch;
  logic [7:0] pc_dir_eff;
  logic [7:0] pc_out_eff;
  logic [7:0] pb_oe_n_eff;

  // ****************************************************************
  // Write channel: address and data taken in either order.
  // ****************************************************************
  assign commit = aw_full && w_full && (wstate == tgp_pkg::TGP_W_IDLE);
  assign wr_lane0 = commit && w_strb[0];

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      aw_full <= 1'b0;
      aw_idx <= 10'h000;
      s_axi_awready_o <= 1'b0;
    end
    else if (s_axi_awvalid_i && s_axi_awready_o)
    begin
      aw_full <= 1'b1;
      aw_idx <= s_axi_awaddr_i[11:2];
      s_axi_awready_o <= 1'b0;
    end
    else
    begin
      if (commit)
      begin
        aw_full <= 1'b0;
      end
      s_axi_awready_o <= !aw_full && (wstate == tgp_pkg::TGP_W_IDLE);
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      w_full <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_wready_o <= 1'b0;
    end
    else if (s_axi_wvalid_i && s_axi_wready_o)
    begin
      w_full <= 1'b1;
      w_data <= s_axi_wdata_i;
      w_strb <= s_axi_wstrb_i;
      s_axi_wready_o <= 1'b0;
    end
    else
    begin
      if (commit)
      begin
        w_full <= 1'b0;
      end
      s_axi_wready_o <= !w_full && (wstate == tgp_pkg::TGP_W_IDLE);
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wstate <= tgp_pkg::TGP_W_IDLE;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= tgp_pkg::RESP_OKAY;
    end
    else
    begin
      case (wstate)
        tgp_pkg::TGP_W_IDLE:
        begin
          if (commit)
          begin
            wstate <= tgp_pkg::TGP_W_RESP;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= index_known(aw_idx) ? tgp_pkg::RESP_OKAY : tgp_pkg::RESP_SLVERR;
          end
        end
        tgp_pkg::TGP_W_RESP:
        begin
          if (s_axi_bready_i)
          begin
            wstate <= tgp_pkg::TGP_W_IDLE;
            s_axi_bvalid_o <= 1'b0;
          end
        end
        default:
        begin
          wstate <= tgp_pkg::TGP_W_IDLE;
          s_axi_bvalid_o <= 1'b0;
        end
      endcase
    end
  end

  function automatic logic index_known(input logic [9:0] idx);
    case (idx)
      tgp_pkg::IDX_PORT_A_DATA, tgp_pkg::IDX_PORT_B_DATA, tgp_pkg::IDX_PORT_C_DATA,
      tgp_pkg::IDX_INTERRUPT_CONTROL, tgp_pkg::IDX_OPTION_CONTROL,
      tgp_pkg::IDX_PORT_A_DIRECTION, tgp_pkg::IDX_PORT_B_DIRECTION,
      tgp_pkg::IDX_PORT_C_DIRECTION, tgp_pkg::IDX_ANALOG_PIN_CONFIG: index_known = 1'b1;
      default: index_known = 1'b0;
    endcase
  endfunction : index_known

  // ****************************************************************
  // Read channel: one cycle from address to data.
  // ****************************************************************
  assign ar_take = s_axi_arvalid_i && s_axi_arready_o;
  assign ar_idx = s_axi_araddr_i[11:2];

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_rerr = 1'b0;
    case (ar_idx)
      tgp_pkg::IDX_PORT_A_DATA: next_rdata[5:0] = pa_pin_i & ~analog_mask;
      tgp_pkg::IDX_PORT_B_DATA: next_rdata[7:0] = pb_pin_i;
      tgp_pkg::IDX_PORT_C_DATA: next_rdata[7:0] = pc_pin_i;
      tgp_pkg::IDX_INTERRUPT_CONTROL: next_rdata[tgp_pkg::PORT_CHANGE_FLAG_BIT] = port_change_flag_o;
      tgp_pkg::IDX_OPTION_CONTROL: next_rdata[7:0] = option_control;
      tgp_pkg::IDX_PORT_A_DIRECTION: next_rdata[5:0] = port_a_direction;
      tgp_pkg::IDX_PORT_B_DIRECTION: next_rdata[7:0] = port_b_direction;
      tgp_pkg::IDX_PORT_C_DIRECTION: next_rdata[7:0] = port_c_direction;
      tgp_pkg::IDX_ANALOG_PIN_CONFIG: next_rdata[2:0] = analog_pin_config;
      default: next_rerr = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= tgp_pkg::RESP_OKAY;
    end
    else if (ar_take)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= next_rdata;
      s_axi_rresp_o <= next_rerr ? tgp_pkg::RESP_SLVERR : tgp_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_rvalid_o && s_axi_rready_i)
      begin
        s_axi_rvalid_o <= 1'b0;
      end
      s_axi_arready_o <= !s_axi_rvalid_o;
    end
  end

  // ****************************************************************
  // Data latches and direction registers.
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      port_a_data <= tgp_pkg::RST_PORT_DATA[5:0];
      port_b_data <= tgp_pkg::RST_PORT_DATA;
      port_c_data <= tgp_pkg::RST_PORT_DATA;
    end
    else if (wr_lane0)
    begin
      if (aw_idx == tgp_pkg::IDX_PORT_A_DATA)
      begin
        port_a_data <= w_data[5:0];
      end
      if (aw_idx == tgp_pkg::IDX_PORT_B_DATA)
      begin
        port_b_data <= w_data[7:0];
      end
      if (aw_idx == tgp_pkg::IDX_PORT_C_DATA)
      begin
        port_c_data <= w_data[7:0];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      port_a_direction <= tgp_pkg::RST_PORT_A_DIRECTION;
      port_b_direction <= tgp_pkg::RST_PORT_B_DIRECTION;
      port_c_direction <= tgp_pkg::RST_PORT_C_DIRECTION;
      option_control <= tgp_pkg::RST_OPTION_CONTROL;
      analog_pin_config <= tgp_pkg::RST_ANALOG_PIN_CONFIG;
    end
    else if (wr_lane0)
    begin
      case (aw_idx)
        tgp_pkg::IDX_PORT_A_DIRECTION: port_a_direction <= w_data[5:0];
        tgp_pkg::IDX_PORT_B_DIRECTION: port_b_direction <= w_data[7:0];
        tgp_pkg::IDX_PORT_C_DIRECTION: port_c_direction <= w_data[7:0];
        tgp_pkg::IDX_OPTION_CONTROL: option_control <= w_data[7:0];
        tgp_pkg::IDX_ANALOG_PIN_CONFIG: analog_pin_config <= w_data[2:0];
        default:
        begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Port B change detection.
  // ****************************************************************
  // The reference is refreshed by any port B data read or write, even a write with no byte lane set.
  assign mismatch = |((pb_pin_i[7:4] ^ change_ref) & port_b_direction[7:4]);

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      change_ref <= 4'h0;
    end
    else if ((ar_take && ar_idx == tgp_pkg::IDX_PORT_B_DATA) ||
             (commit && aw_idx == tgp_pkg::IDX_PORT_B_DATA))
    begin
      change_ref <= pb_pin_i[7:4];
    end
  end

  // A persisting mismatch beats a software clear in the same cycle.
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      port_change_flag_o <= 1'b0;
    end
    else if (mismatch)
    begin
      port_change_flag_o <= 1'b1;
    end
    else if (wr_lane0 && aw_idx == tgp_pkg::IDX_INTERRUPT_CONTROL)
    begin
      port_change_flag_o <= w_data[tgp_pkg::PORT_CHANGE_FLAG_BIT];
    end
  end

  // ****************************************************************
  // Port A analog selection.
  // ****************************************************************
  always_comb
  begin
    vref_on = analog_pin_config[0] && (analog_pin_config[2:1] != 2'h3);
    case (analog_pin_config[2:1])
      2'h0: analog_mask = 6'h2f;
      2'h1: analog_mask = 6'h03;
      2'h2: analog_mask = 6'h01;
      default: analog_mask = 6'h00;
    endcase
    if (vref_on)
    begin
      analog_mask[tgp_pkg::VREF_BIT] = 1'b1;
    end
  end

  // ****************************************************************
  // Port drivers.
  // ****************************************************************
  assign pc_dir_eff = (pc_periph_en_i & pc_periph_dir_i) | (~pc_periph_en_i & port_c_direction);
  assign pc_out_eff = (pc_periph_en_i & pc_periph_out_i) | (~pc_periph_en_i & port_c_data);

  always_comb
  begin
    pb_oe_n_eff = port_b_direction;
    if (prog_mode_i)
    begin
      pb_oe_n_eff[tgp_pkg::PROG_CLK_BIT] = 1'b1;
      pb_oe_n_eff[tgp_pkg::PROG_DATA_BIT] = 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < tgp_pkg::PORT_A_WIDTH; gi++)
    begin : g_pa
      always_ff @(posedge core_clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
        begin
          pa_out_o[gi] <= 1'b0;
          pa_oe_n_o[gi] <= 1'b1;
        end
        else if (gi == tgp_pkg::TIMER_CLK_BIT)
        begin
          pa_out_o[gi] <= 1'b0;
          pa_oe_n_o[gi] <= port_a_direction[gi] | port_a_data[gi];
        end
        else
        begin
          pa_out_o[gi] <= port_a_data[gi];
          pa_oe_n_o[gi] <= port_a_direction[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pb_drive_o <= '{out: 8'h00, oe_n: 8'hff};
      pc_drive_o <= '{out: 8'h00, oe_n: 8'hff};
      pb_pullup_o <= 8'h00;
    end
    else
    begin
      pb_drive_o <= '{out: port_b_data, oe_n: pb_oe_n_eff};
      pc_drive_o <= '{out: pc_out_eff, oe_n: pc_dir_eff};
      pb_pullup_o <= {8{~option_control[tgp_pkg::PULLUP_DISABLE_N_BIT]}} & pb_oe_n_eff;
    end
  end

  // ****************************************************************
  // Alternate inputs to peripherals.
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ext_int_o <= 1'b0;
      prog_clk_o <= 1'b0;
      prog_data_o <= 1'b0;
      timer_ext_clock_in_o <= 1'b0;
      slave_select_o <= 1'b1;
      analog_sel_o <= 6'h00;
      vref_sel_o <= 1'b0;
    end
    else
    begin
      ext_int_o <= pb_pin_i[tgp_pkg::EXT_INT_BIT];
      prog_clk_o <= prog_mode_i & pb_pin_i[tgp_pkg::PROG_CLK_BIT];
      prog_data_o <= prog_mode_i & pb_pin_i[tgp_pkg::PROG_DATA_BIT];
      timer_ext_clock_in_o <= pa_pin_i[tgp_pkg::TIMER_CLK_BIT];
      slave_select_o <= pa_pin_i[tgp_pkg::SLAVE_SEL_BIT] | analog_mask[tgp_pkg::SLAVE_SEL_BIT];
      analog_sel_o <= analog_mask;
      vref_sel_o <= vref_on;
    end
  end

endmodule : tgp_gpio
`default_nettype wire

// [hw/tgp_pkg.sv]
`default_nettype none
package tgp_pkg;

  // ****************************************************************
  // Register indexes; byte address is four times the index.
  // ****************************************************************
  localparam logic [9:0] IDX_PORT_A_DATA = 10'h005;
  localparam logic [9:0] IDX_PORT_B_DATA = 10'h006;
  localparam logic [9:0] IDX_PORT_C_DATA = 10'h007;
  localparam logic [9:0] IDX_INTERRUPT_CONTROL = 10'h00b;
  localparam logic [9:0] IDX_OPTION_CONTROL = 10'h081;
  localparam logic [9:0] IDX_PORT_A_DIRECTION = 10'h085;
  localparam logic [9:0] IDX_PORT_B_DIRECTION = 10'h086;
  localparam logic [9:0] IDX_PORT_C_DIRECTION = 10'h087;
  localparam logic [9:0] IDX_ANALOG_PIN_CONFIG = 10'h09f;

  // ****************************************************************
  // Field positions and widths.
  // ****************************************************************
  localparam int PULLUP_DISABLE_N_BIT = 7;
  localparam int PORT_CHANGE_FLAG_BIT = 0;
  localparam int PORT_A_WIDTH = 6;
  localparam int TIMER_CLK_BIT = 4;
  localparam int SLAVE_SEL_BIT = 5;
  localparam int VREF_BIT = 3;
  localparam int PROG_CLK_BIT = 6;
  localparam int PROG_DATA_BIT = 7;
  localparam int EXT_INT_BIT = 0;

  // ****************************************************************
  // Values after reset.
  // ****************************************************************
  localparam logic [7:0] RST_OPTION_CONTROL = 8'hff;
  localparam logic [5:0] RST_PORT_A_DIRECTION = 6'h3f;
  localparam logic [7:0] RST_PORT_B_DIRECTION = 8'hff;
  localparam logic [7:0] RST_PORT_C_DIRECTION = 8'hff;
  localparam logic [2:0] RST_ANALOG_PIN_CONFIG = 3'h0;
  localparam logic [7:0] RST_PORT_DATA = 8'h00;

  // ****************************************************************
  // AXI4-Lite responses.
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
  } tgp_drive_s;

  typedef enum logic [1:0] {
    TGP_W_IDLE,
    TGP_W_RESP
  } tgp_wstate_e;

endpackage : tgp_pkg
`default_nettype wire

// [test/tgp_gpio_monitor.sv]
`default_nettype none
module tgp_gpio_monitor (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic [5:0] pa_pin_i,
  input wire logic [5:0] pa_out_o,
  input wire logic [7:0] pb_pin_i,
  input wire tgp_pkg::tgp_drive_s pb_drive_o,
  input wire logic [7:0] pb_pullup_o,
  input wire tgp_pkg::tgp_drive_s pc_drive_o,
  input wire logic [7:0] pc_periph_en_i,
  input wire logic [7:0] pc_periph_dir_i,
  input wire logic prog_mode_i,
  input wire logic prog_clk_o,
  input wire logic prog_data_o,
  input wire logic ext_int_o,
  input wire logic timer_ext_clock_in_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Port checks on the core clock.
  // ********
  default clocking mon_cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  AST_PULLUP_OFF_ON_OUTPUT: assert property ((pb_pullup_o & ~pb_drive_o.oe_n) == 8'h00)
    else $error("Pull-up active on a driven port B pin.");
  AST_PULLUP_RESET: assert property ($rose(arst_n_i) |-> pb_pullup_o == 8'h00 && pb_drive_o.oe_n == 8'hff)
    else $error("Port B not released or pull-ups on after reset.");
  AST_TIMER_OPEN_DRAIN: assert property (pa_out_o[tgp_pkg::TIMER_CLK_BIT] == 1'h0)
    else $error("Timer clock pin drives high.");
  AST_TIMER_CLOCK: assert property ($past(arst_n_i) |-> timer_ext_clock_in_o == $past(pa_pin_i[4]))
    else $error("Timer clock does not follow its pin.");
  AST_EXT_INT: assert property ($past(arst_n_i) |-> ext_int_o == $past(pb_pin_i[0]))
    else $error("External interrupt does not follow its pin.");
  AST_PROG_RELEASE: assert property ($past(arst_n_i) && $past(prog_mode_i) |-> pb_drive_o.oe_n[7:6] == 2'h3)
    else $error("Programming pins driven in programming mode.");
  AST_PROG_LINES: assert property ($past(arst_n_i) |->
    {prog_data_o, prog_clk_o} == $past(pb_pin_i[7:6] & {2{prog_mode_i}}))
    else $error("Programming lines do not follow their pins.");
  AST_PC_OVERRIDE: assert property ($past(arst_n_i) |->
    (pc_drive_o.oe_n & $past(pc_periph_en_i)) == ($past(pc_periph_dir_i) & $past(pc_periph_en_i)))
    else $error("Port C direction not taken from the peripheral.");
  AST_PORT_A_UPPER_ZERO: assert property (s_axi_arvalid_i && s_axi_arready_o &&
    s_axi_araddr_i[11:2] == tgp_pkg::IDX_PORT_A_DATA |=> s_axi_rvalid_o && s_axi_rdata_o[31:6] == 26'h000_0000)
    else $error("Port A read shows bits above bit 5.");
endmodule : tgp_gpio_monitor

bind tgp_gpio tgp_gpio_monitor u_monitor (.core_clk_i, .arst_n_i, .s_axi_araddr_i, .s_axi_arvalid_i,
  .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o, .pa_pin_i, .pa_out_o, .pb_pin_i, .pb_drive_o, .pb_pullup_o,
  .pc_drive_o, .pc_periph_en_i, .pc_periph_dir_i, .prog_mode_i, .prog_clk_o, .prog_data_o, .ext_int_o,
  .timer_ext_clock_in_o);
`default_nettype wire

// [test/tgp_pin_model.sv]
`default_nettype none
module tgp_pin_model #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic [W-1:0] out_i,
  input wire logic [W-1:0] oe_n_i,
  input wire logic [W-1:0] pu_i,
  input wire logic [W-1:0] ext_i,
  input wire logic [W-1:0] ext_en_i,
  output logic [W-1:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Pin level.
  // ********
  // The block's driver wins, then the board, then the pull-up; a line nobody holds wanders.
  logic [W-1:0] drift = '0;
  always_ff @(posedge clk_i)
    drift <= ~pin_o;
  always_comb
    for (int k = 0; k < W; k++)
      pin_o[k] = !oe_n_i[k] ? out_i[k] : ext_en_i[k] ? ext_i[k] : pu_i[k] ? 1'h1 : drift[k];
endmodule : tgp_pin_model
`default_nettype wire

// [test/test_three_port_gpio_with_change_irq.sv]
`default_nettype none
module test_three_port_gpio_with_change_irq;
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Bench signals.
  // ********
  localparam logic [1:0] OK = tgp_pkg::RESP_OKAY;
  logic core_clk_i = 1'h0, arst_n_i = 1'h0;
  logic [11:0] s_axi_awaddr_i = 12'h000, s_axi_araddr_i = 12'h000;
  logic [31:0] s_axi_wdata_i = 32'h0000_0000, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i = 4'hf;
  logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
  logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0, prog_mode_i = 1'h0;
  logic [7:0] pc_periph_en_i = 8'h00, pc_periph_dir_i = 8'h00, pc_periph_out_i = 8'h00;
  logic [5:0] pa_ext = 6'h3f;
  logic [7:0] pb_ext = 8'h00, pb_en = 8'h00, pc_ext = 8'hff, pc_en = 8'hff;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [5:0] pa_pin_i, pa_out_o, pa_oe_n_o, analog_sel_o;
  logic [7:0] pb_pin_i, pc_pin_i, pb_pullup_o;
  tgp_pkg::tgp_drive_s pb_drive_o, pc_drive_o;
  logic prog_clk_o, prog_data_o, ext_int_o, timer_ext_clock_in_o, slave_select_o, vref_sel_o, port_change_flag_o;
  int err_total = 0, cmp_count = 0;

  always #10 core_clk_i = ~core_clk_i;

  tgp_gpio dut (.core_clk_i, .arst_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
    .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
    .s_axi_rready_i, .pa_pin_i, .pa_out_o, .pa_oe_n_o, .pb_pin_i, .pb_drive_o, .pb_pullup_o, .pc_pin_i,
    .pc_drive_o, .pc_periph_en_i, .pc_periph_dir_i, .pc_periph_out_i, .prog_mode_i, .prog_clk_o, .prog_data_o,
    .ext_int_o, .timer_ext_clock_in_o, .slave_select_o, .analog_sel_o, .vref_sel_o, .port_change_flag_o);
  tgp_pin_model #(.W(6)) u_pins_a (.clk_i(core_clk_i), .out_i(pa_out_o), .oe_n_i(pa_oe_n_o), .pu_i(6'h00),
    .ext_i(pa_ext), .ext_en_i(6'h3f), .pin_o(pa_pin_i));
  tgp_pin_model #(.W(8)) u_pins_b (.clk_i(core_clk_i), .out_i(pb_drive_o.out), .oe_n_i(pb_drive_o.oe_n),
    .pu_i(pb_pullup_o), .ext_i(pb_ext), .ext_en_i(pb_en), .pin_o(pb_pin_i));
  tgp_pin_model #(.W(8)) u_pins_c (.clk_i(core_clk_i), .out_i(pc_drive_o.out), .oe_n_i(pc_drive_o.oe_n),
    .pu_i(8'h00), .ext_i(pc_ext), .ext_en_i(pc_en), .pin_o(pc_pin_i));

  // ********
  // Shared tasks.
  // ********
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tmo();
    err_total++;
    $display("Error at %0t ns: handshake timeout", $time);
    stop_test();
  endtask : tmo

  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er = OK);
    int n;
    logic [1:0] r;
    s_axi_awaddr_i <= {idx, 2'h0};
    s_axi_wdata_i <= {24'h00_0000, d};
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i <= 1'h1;
    s_axi_bready_i <= 1'h1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge core_clk_i);
      if (s_axi_awready_o)
        s_axi_awvalid_i <= 1'h0;
      if (s_axi_wready_o)
        s_axi_wvalid_i <= 1'h0;
      if (s_axi_bvalid_o)
        break;
    end
    r = s_axi_bresp_o;
    s_axi_bready_i <= 1'h0;
    repeat (3) @(posedge core_clk_i);
    if (n < 50)
      chk(r, er);
    else
      tmo();
  endtask : wr

  task automatic rd(input logic [9:0] idx, input logic [31:0] e, input logic [1:0] er = OK);
    int n;
    logic [33:0] got;
    s_axi_araddr_i <= {idx, 2'h0};
    s_axi_arvalid_i <= 1'h1;
    s_axi_rready_i <= 1'h1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge core_clk_i);
      if (s_axi_arready_o)
        s_axi_arvalid_i <= 1'h0;
      if (s_axi_rvalid_o)
        break;
    end
    got = {s_axi_rresp_o, s_axi_rdata_o};
    s_axi_rready_i <= 1'h0;
    @(posedge core_clk_i);
    if (n < 50)
    begin
      chk(got[31:0], e);
      chk(got[33:32], er);
    end
    else
      tmo();
  endtask : rd

  // ********
  // Scenarios.
  // ********
  task automatic t_reset();
    chk(pb_pullup_o, 8'h00);
    rd(tgp_pkg::IDX_OPTION_CONTROL, 32'h0000_00ff);
    rd(tgp_pkg::IDX_PORT_A_DIRECTION, 32'h0000_003f);
    rd(tgp_pkg::IDX_PORT_B_DIRECTION, 32'h0000_00ff);
    rd(tgp_pkg::IDX_PORT_C_DIRECTION, 32'h0000_00ff);
    rd(tgp_pkg::IDX_ANALOG_PIN_CONFIG, 32'h0000_0000);
    rd(tgp_pkg::IDX_PORT_A_DATA, 32'h0000_0010);
    rd(10'h001, 32'h0000_0000, tgp_pkg::RESP_SLVERR);
    $display("Reset test done");
  endtask : t_reset

  task automatic t_port_b();
    wr(tgp_pkg::IDX_OPTION_CONTROL, 8'h7f);
    wr(tgp_pkg::IDX_PORT_B_DIRECTION, 8'h0f);
    wr(tgp_pkg::IDX_PORT_B_DATA, 8'ha5);
    chk(pb_drive_o, 16'ha50f);
    chk(pb_pullup_o, 8'h0f);
    rd(tgp_pkg::IDX_PORT_B_DATA, 32'h0000_00af);
    wr(tgp_pkg::IDX_OPTION_CONTROL, 8'hff);
    chk(pb_pullup_o, 8'h00);
    prog_mode_i <= 1'h1;
    repeat (2) @(posedge core_clk_i);
    chk(pb_drive_o.oe_n, 8'hcf);
    prog_mode_i <= 1'h0;
    wr(tgp_pkg::IDX_PORT_B_DIRECTION, 8'hff);
    $display("Port B test done");
  endtask : t_port_b

  task automatic t_change();
    pb_ext <= 8'h00;
    pb_en <= 8'hff;
    @(posedge core_clk_i);
    rd(tgp_pkg::IDX_PORT_B_DATA, 32'h0000_0000);
    wr(tgp_pkg::IDX_INTERRUPT_CONTROL, 8'h00);
    chk(port_change_flag_o, 1'h0);
    pb_ext <= 8'h04;
    repeat (3) @(posedge core_clk_i);
    chk(port_change_flag_o, 1'h0);
    // The flag alone is watched while waiting, so the reference stays put.
    pb_ext <= 8'h24;
    repeat (3) @(posedge core_clk_i);
    chk(port_change_flag_o, 1'h1);
    rd(tgp_pkg::IDX_INTERRUPT_CONTROL, 32'h0000_0001);
    wr(tgp_pkg::IDX_INTERRUPT_CONTROL, 8'h00);
    chk(port_change_flag_o, 1'h1);
    rd(tgp_pkg::IDX_PORT_B_DATA, 32'h0000_0024);
    wr(tgp_pkg::IDX_INTERRUPT_CONTROL, 8'h00);
    chk(port_change_flag_o, 1'h0);
    pb_ext <= 8'h04;
    repeat (3) @(posedge core_clk_i);
    chk(port_change_flag_o, 1'h1);
    wr(tgp_pkg::IDX_PORT_B_DATA, 8'h00);
    wr(tgp_pkg::IDX_INTERRUPT_CONTROL, 8'h00);
    chk(port_change_flag_o, 1'h0);
    $display("Change detect test done");
  endtask : t_change

  task automatic t_port_a();
    pa_ext <= 6'h00;
    wr(tgp_pkg::IDX_ANALOG_PIN_CONFIG, 8'h06);
    wr(tgp_pkg::IDX_PORT_A_DIRECTION, 8'hc0);
    rd(tgp_pkg::IDX_PORT_A_DIRECTION, 32'h0000_0000);
    wr(tgp_pkg::IDX_PORT_A_DATA, 8'hff);
    chk({pa_oe_n_o, pa_out_o}, 12'h42f);
    rd(tgp_pkg::IDX_PORT_A_DATA, 32'h0000_002f);
    wr(tgp_pkg::IDX_PORT_A_DATA, 8'h00);
    chk({pa_oe_n_o, slave_select_o}, 7'h00);
    wr(tgp_pkg::IDX_ANALOG_PIN_CONFIG, 8'h01);
    chk({vref_sel_o, analog_sel_o, slave_select_o}, 8'hdf);
    wr(tgp_pkg::IDX_ANALOG_PIN_CONFIG, 8'h02);
    chk({vref_sel_o, analog_sel_o}, 7'h03);
    $display("Port A test done");
  endtask : t_port_a

  task automatic t_port_c();
    // Direction is written whole, once, before any override is switched on.
    wr(tgp_pkg::IDX_PORT_C_DIRECTION, 8'h00);
    wr(tgp_pkg::IDX_PORT_C_DATA, 8'h3c);
    pc_periph_en_i <= 8'h0f;
    pc_periph_dir_i <= 8'h05;
    pc_periph_out_i <= 8'h0a;
    repeat (2) @(posedge core_clk_i);
    chk(pc_drive_o, 16'h3a05);
    rd(tgp_pkg::IDX_PORT_C_DATA, 32'h0000_003f);
    pc_periph_en_i <= 8'h00;
    pc_en <= 8'h00;
    repeat (2) @(posedge core_clk_i);
    chk(pc_drive_o, 16'h3c00);
    rd(tgp_pkg::IDX_PORT_C_DATA, 32'h0000_003c);
    // A write with no byte lane set is answered but changes nothing.
    s_axi_wstrb_i <= 4'h0;
    wr(tgp_pkg::IDX_PORT_C_DIRECTION, 8'hff);
    rd(tgp_pkg::IDX_PORT_C_DIRECTION, 32'h0000_0000);
    s_axi_wstrb_i <= 4'hf;
    wr(10'h001, 8'h55, tgp_pkg::RESP_SLVERR);
    $display("Port C test done");
  endtask : t_port_c

  initial
  begin
    repeat (4) @(posedge core_clk_i);
    arst_n_i <= 1'h1;
    @(posedge core_clk_i);
    t_reset();
    t_port_b();
    t_change();
    t_port_a();
    t_port_c();
    stop_test();
  end
endmodule : test_three_port_gpio_with_change_irq
`default_nettype wire
